// *** hdl/dutc_top.sv ***
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
module dutc_top #(
    parameter int TRIG_COUNT = dutc_pkg::TRIG_N
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic [dutc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [dutc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [TRIG_COUNT-1:0]       trigger_flags,
    output logic [dutc_pkg::CODE_W-1:0]      converter_code,
    output logic                             converter_enable,
    output logic                             pin_output_enable
);
    import dutc_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave state
    // ----------------------------------------------------------------
    logic              aw_have;
    logic              next_aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic              w_have;
    logic              next_w_have;
    logic [31:0]       w_data;
    logic [31:0]       next_w_data;
    logic [3:0]        w_strb;
    logic [3:0]        next_w_strb;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic [31:0]       rd_word;
    logic              wr_go;

    // ----------------------------------------------------------------
    // Converter control state
    // ----------------------------------------------------------------
    logic [7:0]        control;
    logic [7:0]        next_control;
    logic [7:0]        code_high_byte;
    logic [7:0]        next_code_high_byte;
    logic [7:0]        code_low_byte;
    logic [7:0]        next_code_low_byte;
    logic              pair_ready;
    logic              next_pair_ready;
    logic              left_at_high;
    logic              next_left_at_high;
    logic              enable_prev;
    logic              next_enable_prev;
    logic              wr_control;
    logic              wr_high;
    logic              wr_low;
    logic              auto_mode;
    logic              enable_rise;
    logic              manual_load;
    logic              trig_load;
    logic              load;
    logic [CODE_W-1:0] load_code;
    logic              trig_level;
    logic              trig_edge;
    logic              busy;

    if (TRIG_COUNT != TRIG_N) begin : g_check
        $error("eight trigger flags are required");
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Address and data are held until both are in, so either order works
    assign wr_go = aw_have && w_have && !s_axi_bvalid;

    always_comb begin
        rd_word = WORD_ZERO;
        case (s_axi_araddr)
            ADDR_CONTROL: rd_word[7:0] = control;
            ADDR_HIGH:    rd_word[7:0] = code_high_byte;
            ADDR_LOW:     rd_word[7:0] = code_low_byte;
            ADDR_STATUS: begin
                rd_word[STAT_BUSY]  = busy;
                rd_word[STAT_LEVEL] = trig_level;
                rd_word[STAT_PAIR]  = pair_ready;
            end
            default:      rd_word = WORD_ZERO;
        endcase
    end

    always_comb begin
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have  = w_have;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_have = 1'b0;
            next_w_have  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = dutc_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid  = 1'b1;
            next_arready = 1'b0;
            next_rdata   = rd_word;
            next_rresp   = dutc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_awready = !next_aw_have;
        next_wready  = !next_w_have;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_have       <= 1'b0;
            aw_addr       <= ADDR_CONTROL;
            w_have        <= 1'b0;
            w_data        <= WORD_ZERO;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= WORD_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            aw_have       <= next_aw_have;
            aw_addr       <= next_aw_addr;
            w_have        <= next_w_have;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // Control and code registers
    // ----------------------------------------------------------------
    always_comb begin
        wr_control  = wr_go && w_strb[0] && (aw_addr == ADDR_CONTROL);
        wr_high     = wr_go && w_strb[0] && (aw_addr == ADDR_HIGH);
        wr_low      = wr_go && w_strb[0] && (aw_addr == ADDR_LOW);
        auto_mode   = control[BIT_AUTO];
        enable_rise = control[BIT_ENABLE] && !enable_prev;
        manual_load = wr_high && !auto_mode;
        // Select field only reaches the load while auto mode is on
        trig_load   = auto_mode && trig_edge && !busy && pair_ready;
        load        = manual_load || trig_load || (enable_rise && pair_ready);
        if (manual_load) begin
            load_code = dutc_map_code(w_data[7:0], code_low_byte,
                                      control[BIT_LEFT]);
        end else begin
            load_code = dutc_map_code(code_high_byte, code_low_byte,
                                      left_at_high);
        end
    end

    always_comb begin
        next_control        = control;
        next_code_high_byte = code_high_byte;
        next_code_low_byte  = code_low_byte;
        next_pair_ready     = pair_ready;
        next_left_at_high   = left_at_high;
        next_enable_prev    = control[BIT_ENABLE];
        if (wr_control) begin
            next_control = w_data[7:0] & CONTROL_WMASK;
        end
        if (wr_low) begin
            next_code_low_byte = w_data[7:0];
            next_pair_ready    = 1'b0;
        end
        if (wr_high) begin
            next_code_high_byte = w_data[7:0];
            next_pair_ready     = 1'b1;
            next_left_at_high   = control[BIT_LEFT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control        <= CONTROL_RESET;
            code_high_byte <= BYTE_RESET;
            code_low_byte  <= BYTE_RESET;
            pair_ready     <= 1'b1;
            left_at_high   <= 1'b0;
            enable_prev    <= 1'b0;
        end else begin
            control        <= next_control;
            code_high_byte <= next_code_high_byte;
            code_low_byte  <= next_code_low_byte;
            pair_ready     <= next_pair_ready;
            left_at_high   <= next_left_at_high;
            enable_prev    <= next_enable_prev;
        end
    end

    assign converter_enable  = control[BIT_ENABLE];
    assign pin_output_enable = control[BIT_PIN_OE];

    // ----------------------------------------------------------------
    // Trigger and shadow
    // ----------------------------------------------------------------
    dutc_trigger_detect #(
        .TRIG_COUNT     (TRIG_COUNT)
    ) u_trigger (
        .clock          (clock),
        .rst            (rst),
        .trigger_flags  (trigger_flags),
        .trigger_select (control[SEL_MSB:SEL_LSB]),
        .trig_level     (trig_level),
        .trig_edge      (trig_edge)
    );

    // One code drives both comparator references and the pin driver
    dutc_shadow #(
        .CODE_WIDTH (CODE_W)
    ) u_shadow (
        .clock      (clock),
        .rst        (rst),
        .load       (load),
        .load_code  (load_code),
        .code       (converter_code),
        .busy       (busy)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    manual_load_a: assert property (
        (wr_high && !auto_mode) |=> (converter_code ==
            dutc_map_code($past(w_data[7:0]), code_low_byte,
                          $past(control[BIT_LEFT]))))
        else $error("high write did not load the code in manual mode");

    shadow_hold_a: assert property (
        !load |=> $stable(converter_code))
        else $error("code changed without a load");

    low_only_a: assert property (
        (wr_low && !load) |=> !pair_ready ##0 $stable(converter_code))
        else $error("low write reached the converter");

    auto_edge_a: assert property (
        (auto_mode && trig_edge && !busy && pair_ready) |=> busy)
        else $error("rising trigger edge did not start a conversion");

    busy_window_a: assert property (
        busy |-> $past(load))
        else $error("busy without a load one cycle before");

    edge_ignore_a: assert property (
        (busy && trig_edge && !manual_load && !enable_rise)
            |=> !busy ##0 $stable(converter_code))
        else $error("trigger edge taken during a conversion");

    held_level_a: assert property (
        (trig_level && $stable(control[SEL_MSB:SEL_LSB])
            && $past(trig_level)) |-> !trig_edge)
        else $error("level held high caused a new edge");

    select_mute_a: assert property (
        (!auto_mode && !wr_high && !enable_rise)
            |=> $stable(converter_code))
        else $error("trigger load outside auto mode");

    auto_write_a: assert property (
        (auto_mode && wr_high && !trig_load && !enable_rise)
            |=> $stable(converter_code))
        else $error("high write loaded the code in auto mode");

    reserved_zero_a: assert property (
        !control[BIT_RSVD])
        else $error("reserved control bit is set");

    enable_start_a: assert property (
        (enable_rise && pair_ready) |=> busy)
        else $error("enable did not start a conversion");

    manual_cov: cover property (wr_high && !auto_mode ##1 busy);
    auto_cov: cover property (trig_load ##1 busy);
    ignored_cov: cover property (busy && auto_mode && trig_edge);
    left_cov: cover property (wr_high && control[BIT_LEFT]);
endmodule // dutc_top

// *** hdl/dutc_pkg.sv ***
// How it works
// - A 10-bit code is held and drives the converter core input.
// - Software sees a control register plus high and low code registers.
// - Setting the enable bit converts the code held in the data registers, unless a low write still awaits its high write.
// - Control bit 7 selects auto-trigger mode; the select field names the source.
// - Without auto-trigger, writing the high register updates the converter.
// - The 3-bit select field, bits 6:4, picks the load source only in auto-trigger mode; the status level bit follows it in any mode.
// - Select codes 0..7 map to the eight flag inputs in listed order.
// - In auto-trigger mode a rising edge of the source loads the code.
// - Edges are taken from the raw flag, ignoring any interrupt enables.
// - A source that simply stays high never starts another conversion.
// - Rising edges arriving during a conversion are ignored.
// - The held code feeds comparator references and the pin driver.
// - A hidden shadow register loads on high writes in manual mode.
// - A low write alone never reaches the converter; write low then high.
// - Left adjust maps code 9:2 to high, 1:0 to low 7:6.
// - A left adjust change takes effect at the next high write.
package dutc_pkg;
    localparam int CODE_W = 10;
    localparam int TRIG_N = 8;
    localparam int SEL_W  = 3;
    localparam int ADDR_W = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_HIGH    = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_LOW     = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'hc;

    localparam int BIT_ENABLE = 0;
    localparam int BIT_PIN_OE = 1;
    localparam int BIT_LEFT   = 2;
    localparam int BIT_RSVD   = 3;
    localparam int SEL_LSB    = 4;
    localparam int SEL_MSB    = 6;
    localparam int BIT_AUTO   = 7;

    localparam int STAT_BUSY  = 0;
    localparam int STAT_LEVEL = 1;
    localparam int STAT_PAIR  = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'hf7;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Trigger sources in select-field order
    typedef enum logic [SEL_W-1:0] {
        DUTC_TRIG_COMP0,
        DUTC_TRIG_COMP1,
        DUTC_TRIG_EXT0,
        DUTC_TRIG_T0_MATCH,
        DUTC_TRIG_T0_OVF,
        DUTC_TRIG_T1_MATCH_B,
        DUTC_TRIG_T1_OVF,
        DUTC_TRIG_T1_CAPTURE
    } dutc_trig_e;

    function automatic logic [CODE_W-1:0] dutc_map_code(
        input logic [7:0] high,
        input logic [7:0] low,
        input logic       left
    );
        dutc_map_code = left ? {high, low[7:6]} : {high[1:0], low};
    endfunction

    function automatic logic dutc_mapped(input logic [ADDR_W-1:0] addr);
        dutc_mapped = (addr == ADDR_CONTROL) || (addr == ADDR_HIGH) ||
                      (addr == ADDR_LOW) || (addr == ADDR_STATUS);
    endfunction
endpackage

// *** hdl/dutc_trigger_detect.sv ***
module dutc_trigger_detect #(
    parameter int TRIG_COUNT = dutc_pkg::TRIG_N
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic [TRIG_COUNT-1:0]      trigger_flags,
    input  wire logic [dutc_pkg::SEL_W-1:0] trigger_select,
    output logic                            trig_level,
    output logic                            trig_edge
);
    import dutc_pkg::*;

    logic prev_level;
    logic next_prev_level;

    if (TRIG_COUNT != (1 << SEL_W)) begin : g_check
        $error("trigger count must match the select field");
    end

    always_comb begin
        trig_level      = trigger_flags[trigger_select];
        trig_edge       = trig_level && !prev_level;
        next_prev_level = trig_level;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= next_prev_level;
        end
    end
endmodule // dutc_trigger_detect

// *** hdl/dutc_shadow.sv ***
module dutc_shadow #(
    parameter int CODE_WIDTH = dutc_pkg::CODE_W
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  load,
    input  wire logic [CODE_WIDTH-1:0] load_code,
    output logic      [CODE_WIDTH-1:0] code,
    output logic                       busy
);
    import dutc_pkg::*;

    logic [CODE_WIDTH-1:0] next_code;
    logic                  next_busy;

    if (CODE_WIDTH != CODE_W) begin : g_check
        $error("code width must be 10");
    end

    always_comb begin
        next_code = load ? load_code : code;
        next_busy = load;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            code <= CODE_RESET;
            busy <= 1'b0;
        end else begin
            code <= next_code;
            busy <= next_busy;
        end
    end
endmodule // dutc_shadow

// *** sim/tb_dutc_top.sv ***
module tb_dutc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dutc_pkg::*;

    logic                  clock;
    logic                  rst;
    logic [ADDR_W-1:0]     s_axi_awaddr;
    logic                  s_axi_awvalid;
    logic                  s_axi_awready;
    logic [31:0]           s_axi_wdata;
    logic [3:0]            s_axi_wstrb;
    logic                  s_axi_wvalid;
    logic                  s_axi_wready;
    logic [1:0]            s_axi_bresp;
    logic                  s_axi_bvalid;
    logic                  s_axi_bready;
    logic [ADDR_W-1:0]     s_axi_araddr;
    logic                  s_axi_arvalid;
    logic                  s_axi_arready;
    logic [31:0]           s_axi_rdata;
    logic [1:0]            s_axi_rresp;
    logic                  s_axi_rvalid;
    logic                  s_axi_rready;
    logic [TRIG_N-1:0]     trigger_flags;
    logic [CODE_W-1:0]     converter_code;
    logic                  converter_enable;
    logic                  pin_output_enable;
    int                    miscompares;
    int                    checks;
    logic [CODE_W-1:0]     prev;
    logic [CODE_W-1:0]     exp_code;
    logic [1:0]            resp;
    logic [31:0]           rdata;

    dutc_top #(.TRIG_COUNT(TRIG_N)) uut (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .trigger_flags(trigger_flags),
        .converter_code(converter_code),
        .converter_enable(converter_enable),
        .pin_output_enable(pin_output_enable)
    );

    always #2 clock = ~clock;

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(string name, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_code(string name, logic [CODE_W-1:0] e);
        checks++;
        if (converter_code !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, e, converter_code);
        end
    endtask

    task automatic check_pin(string name, logic e, logic g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", name, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    // Waits end only at the answer; the watchdog catches a dead handshake
    task automatic axi_write(logic [ADDR_W-1:0] a, logic [7:0] d,
                             output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(logic [ADDR_W-1:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic reg_wr(logic [ADDR_W-1:0] a, logic [7:0] d);
        axi_write(a, d, resp);
        check_reg("write response", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask

    task automatic reg_rd(logic [ADDR_W-1:0] a, logic [31:0] e);
        axi_read(a, rdata, resp);
        check_reg("read response", {30'h0, RESP_OKAY}, {30'h0, resp});
        check_reg("read data", e, rdata);
    endtask

    // Code moves one edge after the load; three edges cover it
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic pulse(int i);
        @(posedge clock);
        trigger_flags[i] <= 1'b1;
        @(posedge clock);
        trigger_flags[i] <= 1'b0;
        settle();
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        trigger_flags = '0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        settle();
        check_code("code after reset", 10'h000);
        check_pin("enable after reset", 1'b0, converter_enable);
        reg_rd(ADDR_STATUS, 32'h0000_0004);
        reg_rd(ADDR_CONTROL, 32'h0000_0000);
        reg_wr(ADDR_CONTROL, 8'hff);
        reg_rd(ADDR_CONTROL, 32'h0000_00f7);
        check_pin("enable", 1'b1, converter_enable);
        check_pin("pin enable", 1'b1, pin_output_enable);
        reg_wr(ADDR_CONTROL, 8'h03);
        reg_wr(ADDR_LOW, 8'ha5);
        settle();
        check_code("low only", 10'h000);
        reg_wr(ADDR_HIGH, 8'h02);
        settle();
        check_code("manual load", 10'h2a5);
        reg_rd(ADDR_HIGH, 32'h0000_0002);
        reg_wr(ADDR_CONTROL, 8'h07);
        settle();
        check_code("left change alone", 10'h2a5);
        reg_wr(ADDR_LOW, 8'hc0);
        reg_wr(ADDR_HIGH, 8'h9b);
        settle();
        check_code("left load", 10'h26f);
        axi_write(4'h2, 8'h11, resp);
        check_reg("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_read(4'h6, rdata, resp);
        check_reg("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
        check_reg("unmapped data", WORD_ZERO, rdata);
        // Each source in turn; the next index must not fire
        prev = 10'h26f;
        for (int s = 0; s < TRIG_N; s++) begin
            reg_wr(ADDR_CONTROL, {1'b1, 3'(s), 4'h1});
            reg_wr(ADDR_LOW, 8'h10 + 8'(s));
            reg_wr(ADDR_HIGH, {6'h00, 2'(s)});
            exp_code = {2'(s), 8'h10 + 8'(s)};
            settle();
            check_code("auto high write", prev);
            pulse((s + 1) % TRIG_N);
            check_code("other source", prev);
            pulse(s);
            check_code("selected source", exp_code);
            prev = exp_code;
        end
        reg_wr(ADDR_CONTROL, 8'h71);
        reg_wr(ADDR_LOW, 8'h33);
        pulse(7);
        check_code("select in manual", prev);
        reg_wr(ADDR_HIGH, 8'h01);
        settle();
        check_code("manual after select", 10'h133);
        reg_wr(ADDR_CONTROL, 8'hb1);
        @(posedge clock);
        trigger_flags[3] <= 1'b1;
        reg_wr(ADDR_LOW, 8'h44);
        reg_wr(ADDR_HIGH, 8'h02);
        settle();
        check_code("level held", 10'h133);
        reg_rd(ADDR_STATUS, 32'h0000_0006);
        @(posedge clock);
        trigger_flags[3] <= 1'b0;
        pulse(3);
        check_code("fresh edge", 10'h244);
        reg_wr(ADDR_LOW, 8'h55);
        reg_rd(ADDR_STATUS, 32'h0000_0000);
        pulse(3);
        check_code("low then trigger", 10'h244);
        reg_wr(ADDR_HIGH, 8'h03);
        pulse(3);
        check_code("pair then trigger", 10'h355);
        reg_wr(ADDR_CONTROL, 8'hb0);
        check_pin("pin off", 1'b0, pin_output_enable);
        reg_wr(ADDR_LOW, 8'h66);
        reg_wr(ADDR_HIGH, 8'h01);
        settle();
        check_code("disabled hold", 10'h355);
        reg_wr(ADDR_CONTROL, 8'hb1);
        // Edge lands in the busy cycle after the enable load and is lost
        trigger_flags[3] <= 1'b1;
        settle();
        check_code("enable load", 10'h166);
        reg_rd(ADDR_STATUS, 32'h0000_0006);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule // tb_dutc_top
